/* File: inc/dbg_wire_defines.svh */
// Constants of the single-wire debug controller
`ifndef DBG_WIRE_DEFINES_SVH
`define DBG_WIRE_DEFINES_SVH

// ==========================================================
// Timing in debug clock cycles; bit timing counted from the perceived bit start, steal wait and reject delay not
`define BIT_SAMPLE_CYC   10'h00a
`define SPEEDUP_ONE_CYC  10'h007
`define ZERO_LOW_CYC     10'h00d
`define BIT_END_CYC      10'h00f
`define TIMEOUT_CYC      10'h200
`define STEAL_WAIT_CYC   8'h7f
`define REJECT_DELAY_CYC 3'h4

// ==========================================================
// Hardware command opcodes
`define OP_BACKGROUND    8'h90
`define OP_MEM_MASK      8'hc0
`define OP_READ_BIT      5
`define OP_BD_BIT        2
`define OP_WORD_BIT      3
`define OP_FW_BIT        7

// ==========================================================
// Debug space map
`define DBG_SPACE_BASE   16'hff00
`define DBG_REG_LAST     16'hff06
`define DBG_STATUS_ADDR  16'hff01
`define STATUS_FW_EN_BIT 7
`define STATUS_ACT_BIT   6

// ==========================================================
// Receive buffer
`define RX_FIFO_DEPTH    16
`define RX_FIFO_WIDTH    8

`endif

/* File: inc/dbg_wire_pkg.sv */
// Types shared by the single-wire debug controller
package dbg_wire_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;

  typedef enum logic [2:0] {
    CMD_IDLE    = 3'b000,
    CMD_ADDR_HI = 3'b001,
    CMD_ADDR_LO = 3'b010,
    CMD_DATA_HI = 3'b011,
    CMD_DATA_LO = 3'b100,
    CMD_ACCESS  = 3'b101,
    CMD_RDATA   = 3'b110,
    CMD_SEND    = 3'b111
  } cmd_state_e;
endpackage : dbg_wire_pkg

/* File: src/byte_fifo.sv */
// First-in first-out buffer with a registered read port
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             flush_i,
  // Write side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             load;

  assign in_ready_o = (count_r != DEPTH[AW:0]);
  assign push       = in_valid_i && in_ready_o;
  assign load       = (count_r != '0) && (!out_valid_o || out_ready_i);

  // ==========================================================
  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  // ==========================================================
  // Pointers and fill level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (load) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end

  // ==========================================================
  // Output register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (flush_i) begin
      out_valid_o <= 1'b0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_ptr_r];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule : byte_fifo

/* File: src/debug_wire_ctrl.sv */
// Background debug controller behind a single pseudo-open-drain wire
// Contract
// - MSB first, sixteen cycles per bit
// - 512 idle cycles time out, clear command
// - Synchronise host edge into device clock
// - Sample received bit ten cycles after start
// - Never drive wire during host bits
// - Firmware enable set via debug-space write
// - Activation overlays debug space, enters background
// - Enter on command, tag or halt
// - Not enabled: resume after brief delay
// - Command at boundary, tag before execution
// - Special single-chip: enabled, active out of reset
// - Debug registers readable only by debug logic
// - Hardware commands use idle bus cycles
// - Firmware commands and ROM only when active
// - Suspend-enabled peripherals halt while active
// - Serial interface works in every mode
// - Speed-up pulse seven cycles after start
// - Logic zero: low thirteen cycles, then high
// - No idle cycle in 128: freeze, steal
`timescale 1ns/10ps
`include "dbg_wire_defines.svh"
module debug_wire_ctrl (
  // Clock and reset
  input  wire logic               CLK_I,
  input  wire logic               ARST_N_I,
  // Debug wire
  input  wire logic               DBG_WIRE_I,
  output logic                    DBG_WIRE_O,
  output logic                    DBG_WIRE_OE_O,
  // Mode strap
  input  wire logic               SPECIAL_SC_I,
  // Processor status
  input  wire logic               CPU_BUS_IDLE_I,
  input  wire logic               CPU_INSTR_BOUNDARY_I,
  input  wire logic               CPU_TAG_HIT_I,
  input  wire logic               CPU_HALT_INSTR_I,
  input  wire logic               CPU_GO_I,
  output logic                    CPU_FREEZE_O,
  // Memory access
  output logic                    MEM_REQ_O,
  output logic                    MEM_WE_O,
  output logic                    MEM_BYTE_O,
  output logic                    MEM_DBG_SPACE_O,
  output dbg_wire_pkg::word_t     MEM_ADDR_O,
  output dbg_wire_pkg::word_t     MEM_WDATA_O,
  input  wire dbg_wire_pkg::word_t MEM_RDATA_I,
  // Debug mode state
  output logic                    DEBUG_ACTIVE_O,
  output logic                    DEBUG_OVERLAY_O,
  output logic                    FW_ENABLE_O,
  output logic                    FW_CMD_VALID_O,
  output dbg_wire_pkg::byte_t     FW_CMD_O,
  // Peripheral suspension
  input  wire logic [7:0]         PERIPH_SUSP_EN_I,
  output logic      [7:0]         PERIPH_HALT_O
);
  import dbg_wire_pkg::*;

  logic       w_s1_r, w_s2_r, w_s3_r;
  logic       fall;
  logic [9:0] bit_cnt_r;
  logic       link_live_r;
  logic       timeout;
  logic [7:0] rx_shift_r;
  logic [2:0] rx_bits_r;
  logic       rx_push_r;
  byte_t      rx_byte_r;
  logic       fifo_in_ready, fifo_out_valid, fifo_pop;
  byte_t      fifo_out_data;
  cmd_state_e state_r;
  byte_t      op_r;
  word_t      addr_r, data_r;
  logic [7:0] wait_r;
  logic [4:0] tx_bits_r;
  logic       tx_bit_r;
  logic       fw_en_r, active_r, bg_pend_r, init_done_r;
  logic [2:0] reject_r;
  logic       reg_hit;

  // Decoding shared by the command path
  function automatic logic is_mem_op(input byte_t op);
    return (op & `OP_MEM_MASK) == `OP_MEM_MASK;
  endfunction : is_mem_op

  function automatic logic in_dbg_regs(input word_t a);
    return (a >= `DBG_SPACE_BASE) && (a <= `DBG_REG_LAST);
  endfunction : in_dbg_regs

  // ==========================================================
  // Host edge synchroniser and bit counter
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      w_s1_r <= 1'b1;
      w_s2_r <= 1'b1;
      w_s3_r <= 1'b1;
    end else begin
      w_s1_r <= DBG_WIRE_I;
      w_s2_r <= w_s1_r;
      w_s3_r <= w_s2_r;
    end
  end

  assign fall    = w_s3_r && !w_s2_r;
  assign timeout = link_live_r && !fall && (bit_cnt_r == `TIMEOUT_CYC - 10'h001);

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bit_cnt_r   <= `TIMEOUT_CYC;
      link_live_r <= 1'b0;
    end else if (fall) begin
      bit_cnt_r   <= '0;
      link_live_r <= 1'b1;
    end else if (bit_cnt_r != `TIMEOUT_CYC) begin
      bit_cnt_r <= bit_cnt_r + 10'h001;
      if (timeout) begin
        link_live_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive shifter, one byte pushed into the buffer at a time
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_shift_r <= '0;
      rx_bits_r  <= '0;
      rx_push_r  <= 1'b0;
      rx_byte_r  <= '0;
    end else if (timeout) begin
      rx_bits_r <= '0;
      rx_push_r <= 1'b0;
    end else begin
      if (rx_push_r && fifo_in_ready) begin
        rx_push_r <= 1'b0;
      end
      // Samples are skipped while a byte still waits for room
      if (state_r != CMD_SEND && !rx_push_r && link_live_r && bit_cnt_r == `BIT_SAMPLE_CYC) begin
        rx_shift_r <= {rx_shift_r[6:0], w_s2_r};
        rx_bits_r  <= rx_bits_r + 3'h1;
        if (rx_bits_r == 3'h7) begin
          rx_push_r <= 1'b1;
          rx_byte_r <= {rx_shift_r[6:0], w_s2_r};
        end
      end
    end
  end

  byte_fifo #(
    .WIDTH (`RX_FIFO_WIDTH),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .flush_i     (timeout),
    .in_valid_i  (rx_push_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_byte_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  assign fifo_pop = (state_r == CMD_IDLE) || (state_r == CMD_ADDR_HI) || (state_r == CMD_ADDR_LO) ||
                    (state_r == CMD_DATA_HI) || (state_r == CMD_DATA_LO);
  assign reg_hit  = op_r[`OP_BD_BIT] && in_dbg_regs(addr_r);

  // ==========================================================
  // Command sequencer
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_r         <= CMD_IDLE;
      op_r            <= '0;
      addr_r          <= '0;
      data_r          <= '0;
      wait_r          <= '0;
      tx_bits_r       <= '0;
      tx_bit_r        <= 1'b0;
      CPU_FREEZE_O    <= 1'b0;
      MEM_REQ_O       <= 1'b0;
      MEM_WE_O        <= 1'b0;
      MEM_BYTE_O      <= 1'b0;
      MEM_DBG_SPACE_O <= 1'b0;
      MEM_ADDR_O      <= '0;
      MEM_WDATA_O     <= '0;
      FW_CMD_VALID_O  <= 1'b0;
      FW_CMD_O        <= '0;
    end else begin
      MEM_REQ_O      <= 1'b0;
      FW_CMD_VALID_O <= 1'b0;
      CPU_FREEZE_O   <= (reject_r != '0);
      if (timeout) begin
        state_r <= CMD_IDLE;
      end else begin
        unique case (state_r)
          CMD_IDLE: begin
            if (fifo_out_valid) begin
              op_r <= fifo_out_data;
              if (is_mem_op(fifo_out_data)) begin
                state_r <= CMD_ADDR_HI;
              end else if (!fifo_out_data[`OP_FW_BIT] && active_r) begin
                FW_CMD_VALID_O <= 1'b1;
                FW_CMD_O       <= fifo_out_data;
              end
            end
          end
          CMD_ADDR_HI: begin
            if (fifo_out_valid) begin
              addr_r[15:8] <= fifo_out_data;
              state_r      <= CMD_ADDR_LO;
            end
          end
          CMD_ADDR_LO: begin
            if (fifo_out_valid) begin
              addr_r[7:0] <= fifo_out_data;
              wait_r      <= '0;
              state_r     <= op_r[`OP_READ_BIT] ? CMD_ACCESS : CMD_DATA_HI;
            end
          end
          CMD_DATA_HI: begin
            if (fifo_out_valid) begin
              data_r[15:8] <= fifo_out_data;
              state_r      <= CMD_DATA_LO;
            end
          end
          CMD_DATA_LO: begin
            if (fifo_out_valid) begin
              data_r[7:0] <= fifo_out_data;
              state_r     <= CMD_ACCESS;
            end
          end
          CMD_ACCESS: begin
            if (reg_hit) begin
              // Debug registers answer locally, never on the user bus
              data_r  <= {8'h00, fw_en_r, active_r, 6'h00};
              state_r <= op_r[`OP_READ_BIT] ? CMD_SEND : CMD_IDLE;
              tx_bits_r <= 5'h10;
            end else if (CPU_BUS_IDLE_I || CPU_FREEZE_O) begin
              MEM_REQ_O       <= 1'b1;
              MEM_WE_O        <= !op_r[`OP_READ_BIT];
              MEM_BYTE_O      <= !op_r[`OP_WORD_BIT];
              MEM_DBG_SPACE_O <= op_r[`OP_BD_BIT];
              MEM_ADDR_O      <= addr_r;
              MEM_WDATA_O     <= data_r;
              CPU_FREEZE_O    <= 1'b0;
              state_r         <= op_r[`OP_READ_BIT] ? CMD_RDATA : CMD_IDLE;
            end else if (wait_r == `STEAL_WAIT_CYC) begin
              CPU_FREEZE_O <= 1'b1;
            end else begin
              wait_r <= wait_r + 8'h01;
            end
          end
          CMD_RDATA: begin
            data_r    <= MEM_RDATA_I;
            tx_bits_r <= 5'h10;
            state_r   <= CMD_SEND;
          end
          CMD_SEND: begin
            // Bits are counted at host edges, so a bit end left over from the command is ignored
            if (fall) begin
              tx_bit_r  <= data_r[15];
              data_r    <= {data_r[14:0], 1'b0};
              tx_bits_r <= tx_bits_r - 5'h01;
            end else if (link_live_r && tx_bits_r == 5'h00 && bit_cnt_r == `BIT_END_CYC) begin
              state_r <= CMD_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Wire driver for device-to-host bits
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DBG_WIRE_O    <= 1'b1;
      DBG_WIRE_OE_O <= 1'b0;
    end else if (state_r != CMD_SEND || !link_live_r || fall) begin
      DBG_WIRE_O    <= 1'b1;
      DBG_WIRE_OE_O <= 1'b0;
    end else if (!tx_bit_r) begin
      DBG_WIRE_O    <= (bit_cnt_r == `ZERO_LOW_CYC);
      DBG_WIRE_OE_O <= (bit_cnt_r <= `ZERO_LOW_CYC);
    end else begin
      DBG_WIRE_O    <= 1'b1;
      DBG_WIRE_OE_O <= (bit_cnt_r == `SPEEDUP_ONE_CYC - 10'h001);
    end
  end

  // ==========================================================
  // Firmware enable and debug mode activation
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      init_done_r <= 1'b0;
      fw_en_r     <= 1'b0;
      active_r    <= 1'b0;
      bg_pend_r   <= 1'b0;
      reject_r    <= '0;
    end else if (!init_done_r) begin
      init_done_r <= 1'b1;
      fw_en_r     <= SPECIAL_SC_I;
      active_r    <= SPECIAL_SC_I;
    end else begin
      if (reject_r != '0) begin
        reject_r <= reject_r - 3'h1;
      end
      if (state_r == CMD_ACCESS && reg_hit && !op_r[`OP_READ_BIT] && addr_r == `DBG_STATUS_ADDR) begin
        fw_en_r <= data_r[`STATUS_FW_EN_BIT];
      end
      if (state_r == CMD_IDLE && fifo_out_valid && fifo_out_data == `OP_BACKGROUND) begin
        if (fw_en_r) begin
          bg_pend_r <= 1'b1;
        end else begin
          reject_r <= `REJECT_DELAY_CYC;
        end
      end
      if (CPU_TAG_HIT_I || CPU_HALT_INSTR_I) begin
        if (fw_en_r) begin
          active_r <= 1'b1;
        end else begin
          reject_r <= `REJECT_DELAY_CYC;
        end
      end else if (bg_pend_r && CPU_INSTR_BOUNDARY_I) begin
        active_r  <= 1'b1;
        bg_pend_r <= 1'b0;
      end else if (CPU_GO_I && active_r) begin
        active_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Mode outputs and peripheral suspension
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DEBUG_ACTIVE_O  <= 1'b0;
      DEBUG_OVERLAY_O <= 1'b0;
      FW_ENABLE_O     <= 1'b0;
      PERIPH_HALT_O   <= '0;
    end else begin
      DEBUG_ACTIVE_O  <= active_r;
      DEBUG_OVERLAY_O <= active_r;
      FW_ENABLE_O     <= fw_en_r;
      PERIPH_HALT_O   <= PERIPH_SUSP_EN_I & {8{active_r}};
    end
  end
endmodule : debug_wire_ctrl

/* File: tb/dbg_host_model.sv */
// Debug host model driving the shared wire
`timescale 1ns/10ps
module dbg_host_model (
  input  wire logic clk_i,
  input  wire logic wire_i,
  output logic      oe_o,
  output logic      drv_o
);
  initial oe_o = 1'b0;
  initial drv_o = 1'b1;
  // Bit of 20 cycles: low start, then driven high to speed the edge
  task automatic send_bit(input logic b);
    @(posedge clk_i);
    oe_o  <= 1'b1;
    drv_o <= 1'b0;
    repeat (b ? 4 : 15) @(posedge clk_i);
    drv_o <= 1'b1;
    repeat (b ? 15 : 4) @(posedge clk_i);
    oe_o <= 1'b0;
  endtask : send_bit
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask : send_byte
  task automatic recv_word(input int gap, output logic [15:0] v);
    repeat (gap) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_i);
      oe_o  <= 1'b1;
      drv_o <= 1'b0;
      // Low held until the device takes over, released well before the pulse
      repeat (4) @(posedge clk_i);
      oe_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      #1 v[i] = wire_i;
      repeat (11) @(posedge clk_i);
    end
  endtask : recv_word
endmodule : dbg_host_model

/* File: tb/debug_wire_ctrl_sva.sv */
// Port assertions for the debug wire controller
`timescale 1ns/10ps
module debug_wire_ctrl_sva (
  // Clock and reset
  input wire logic       CLK_I,
  input wire logic       ARST_N_I,
  // Wire and processor
  input wire logic       DBG_WIRE_I,
  input wire logic       DBG_WIRE_O,
  input wire logic       DBG_WIRE_OE_O,
  input wire logic       CPU_BUS_IDLE_I,
  input wire logic       CPU_TAG_HIT_I,
  input wire logic       CPU_FREEZE_O,
  input wire logic       MEM_REQ_O,
  // Debug state
  input wire logic       DEBUG_ACTIVE_O,
  input wire logic       DEBUG_OVERLAY_O,
  input wire logic       FW_ENABLE_O,
  input wire logic       FW_CMD_VALID_O,
  input wire logic [7:0] PERIPH_SUSP_EN_I,
  input wire logic [7:0] PERIPH_HALT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic [4:0] low_cnt;
  logic [4:0] fall_cnt;
  logic [2:0] frz_cnt;
  logic       wire_q;
  // Cycles since the host edge, length of low drive and of freeze
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      low_cnt  <= 5'h00;
      fall_cnt <= 5'h1f;
      frz_cnt  <= 3'h0;
      wire_q   <= 1'b1;
    end else begin
      wire_q   <= DBG_WIRE_I;
      low_cnt  <= (DBG_WIRE_OE_O && !DBG_WIRE_O) ? low_cnt + 5'h01 : 5'h00;
      fall_cnt <= (wire_q && !DBG_WIRE_I) ? 5'h00 : (fall_cnt == 5'h1f ? fall_cnt : fall_cnt + 5'h01);
      frz_cnt  <= CPU_FREEZE_O ? (frz_cnt == 3'h7 ? frz_cnt : frz_cnt + 3'h1) : 3'h0;
    end
  end
  property p_zero_start; $rose(DBG_WIRE_OE_O) && !DBG_WIRE_O |-> fall_cnt inside {[5'h02:5'h05]}; endproperty
  a_zero_start: assert property (p_zero_start) else $error("low drive starts off time");
  property p_zero_len; $fell(DBG_WIRE_OE_O && !DBG_WIRE_O) |-> low_cnt == 5'h0d && DBG_WIRE_OE_O && DBG_WIRE_O; endproperty
  a_zero_len: assert property (p_zero_len) else $error("low drive length wrong");
  property p_one_pulse;
    DBG_WIRE_OE_O && DBG_WIRE_O && !$past(DBG_WIRE_OE_O) |-> fall_cnt inside {[5'h08:5'h0b]} ##1 !DBG_WIRE_OE_O;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("speed-up pulse wrong");
  property p_freeze_short; CPU_FREEZE_O |-> frz_cnt < 3'h4; endproperty
  a_freeze_short: assert property (p_freeze_short) else $error("freeze too long");
  property p_req_slot; MEM_REQ_O |-> CPU_BUS_IDLE_I || $past(CPU_BUS_IDLE_I) || CPU_FREEZE_O || $past(CPU_FREEZE_O); endproperty
  a_req_slot: assert property (p_req_slot) else $error("access without free slot");
  property p_tag_entry; CPU_TAG_HIT_I && FW_ENABLE_O && !DEBUG_ACTIVE_O |-> ##[1:3] DEBUG_ACTIVE_O; endproperty
  a_tag_entry: assert property (p_tag_entry) else $error("tag did not activate");
  property p_overlay; DEBUG_ACTIVE_O |-> DEBUG_OVERLAY_O; endproperty
  a_overlay: assert property (p_overlay) else $error("active without overlay");
  property p_rise_needs_fw; $rose(DEBUG_ACTIVE_O) |-> FW_ENABLE_O; endproperty
  a_rise_needs_fw: assert property (p_rise_needs_fw) else $error("active while not enabled");
  property p_fw_cmd_active; FW_CMD_VALID_O |-> DEBUG_ACTIVE_O; endproperty
  a_fw_cmd_active: assert property (p_fw_cmd_active) else $error("firmware command while inactive");
  property p_halt_follow; PERIPH_HALT_O == ($past(PERIPH_SUSP_EN_I) & {8{DEBUG_ACTIVE_O}}); endproperty
  a_halt_follow: assert property (p_halt_follow) else $error("peripheral halt wrong");
endmodule : debug_wire_ctrl_sva

bind debug_wire_ctrl debug_wire_ctrl_sva u_sva (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .DBG_WIRE_I(DBG_WIRE_I),
  .DBG_WIRE_O(DBG_WIRE_O), .DBG_WIRE_OE_O(DBG_WIRE_OE_O), .CPU_BUS_IDLE_I(CPU_BUS_IDLE_I),
  .CPU_TAG_HIT_I(CPU_TAG_HIT_I), .CPU_FREEZE_O(CPU_FREEZE_O), .MEM_REQ_O(MEM_REQ_O),
  .DEBUG_ACTIVE_O(DEBUG_ACTIVE_O), .DEBUG_OVERLAY_O(DEBUG_OVERLAY_O), .FW_ENABLE_O(FW_ENABLE_O),
  .FW_CMD_VALID_O(FW_CMD_VALID_O), .PERIPH_SUSP_EN_I(PERIPH_SUSP_EN_I), .PERIPH_HALT_O(PERIPH_HALT_O));

/* File: tb/tb.sv */
// Self-checking bench for the debug wire controller
`timescale 1ns/10ps
module tb;
  import dbg_wire_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, sc = 1'b0, idle = 1'b1;
  logic dev_o, dev_oe, host_oe, host_o, frz, mreq, mwe, mbyte, mdbg, act, ovl, fw, fwv;
  logic [3:0] ev = 4'h0;
  logic [7:0] susp = 8'h00, halt;
  logic [2:0] r_ctl;
  byte_t      fwop, last_fwc;
  word_t      maddr, mwd, r_addr, r_wd, rdata = 16'h0000;
  word_t      mem_m [word_t];
  logic [31:0] seed;
  int n_fail = 0, comparisons = 0, n_req = 0, n_frz = 0, n_fwc = 0, m_fw = 0, m_act = 0;
  wire wire_lvl = (dev_oe && !dev_o) || (host_oe && !host_o) ? 1'b0 : 1'b1;
  always #20 clk = ~clk;

  debug_wire_ctrl dut (.CLK_I(clk), .ARST_N_I(arst_n), .DBG_WIRE_I(wire_lvl), .DBG_WIRE_O(dev_o),
    .DBG_WIRE_OE_O(dev_oe), .SPECIAL_SC_I(sc), .CPU_BUS_IDLE_I(idle), .CPU_INSTR_BOUNDARY_I(ev[0]),
    .CPU_TAG_HIT_I(ev[1]), .CPU_HALT_INSTR_I(ev[2]), .CPU_GO_I(ev[3]), .CPU_FREEZE_O(frz),
    .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_BYTE_O(mbyte), .MEM_DBG_SPACE_O(mdbg), .MEM_ADDR_O(maddr),
    .MEM_WDATA_O(mwd), .MEM_RDATA_I(rdata), .DEBUG_ACTIVE_O(act), .DEBUG_OVERLAY_O(ovl),
    .FW_ENABLE_O(fw), .FW_CMD_VALID_O(fwv), .FW_CMD_O(fwop), .PERIPH_SUSP_EN_I(susp), .PERIPH_HALT_O(halt));
  dbg_host_model u_host (.clk_i(clk), .wire_i(wire_lvl), .oe_o(host_oe), .drv_o(host_o));

  // Read data stand while the request is up, taken by the controller on the next edge
  always @(mreq, maddr) rdata = (mreq && mem_m.exists(maddr)) ? mem_m[maddr] : 16'h0000;
  // Memory model and event counters
  always @(posedge clk) begin
    if (mreq) begin
      n_req <= n_req + 1;
      r_ctl <= {mwe, mbyte, mdbg};
      r_addr <= maddr;
      r_wd <= mwd;
      if (mwe) mem_m[maddr] = mwd;
    end
    n_frz <= n_frz + int'(frz);
    if (fwv) begin
      n_fwc <= n_fwc + 1;
      last_fwc <= fwop;
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic cond(input int k, input int n0);
    case (k)
      0: return n_req != n0;
      1: return act === 1'b1;
      2: return act === 1'b0;
      default: return fw === 1'b1;
    endcase
  endfunction : cond
  task automatic wait_for(input int k, input int bound, output int t);
    int n0;
    n0 = n_req;
    for (t = 0; t < bound && !cond(k, n0); t++) @(posedge clk);
    check(16'(t < bound), 16'h0001);
    if (t >= bound) print_verdict();
  endtask : wait_for
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
  endtask : pulse
  task automatic send_cmd(input byte_t op, input word_t a, input word_t d, input int n);
    u_host.send_byte(op);
    if (n > 0) u_host.send_byte(a[15:8]);
    if (n > 0) u_host.send_byte(a[7:0]);
    if (n > 2) u_host.send_byte(d[15:8]);
    if (n > 2) u_host.send_byte(d[7:0]);
  endtask : send_cmd
  task automatic read_cmd(input byte_t op, input word_t a, input int gap, input word_t exp);
    word_t v;
    send_cmd(op, a, 16'h0000, 2);
    u_host.recv_word(gap, v);
    check(v, exp);
  endtask : read_cmd
  task automatic do_reset(input logic s);
    arst_n <= 1'b0;
    sc <= s;
    repeat (8) @(posedge clk);
    check({dev_oe, dev_o}, 16'h0001);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  initial begin
    int n0, t;
    word_t a, d;
    seed = 32'h39a1;
    do_reset(1'b0);
    check({fw, act}, 16'h0000);
    n0 = n_frz;
    send_cmd(8'h90, 16'h0000, 16'h0000, 0);
    pulse(0);
    repeat (20) @(posedge clk);
    check(16'(n_frz - n0), 16'h0004);
    check(act, 1'b0);
    n0 = n_fwc;
    send_cmd(8'h64, 16'h0000, 16'h0000, 0);
    repeat (20) @(posedge clk);
    check(16'(n_fwc), 16'(n0));
    $display("test reject done");
    n0 = n_req;
    send_cmd(8'hc4, 16'hff01, 16'h0080, 4);
    wait_for(3, 40, t);
    m_fw = 1;
    check(16'(n_req), 16'(n0));
    read_cmd(8'he4, 16'hff01, 40, {8'h00, m_fw[0], m_act[0], 6'h00});
    send_cmd(8'h90, 16'h0000, 16'h0000, 0);
    repeat (10) @(posedge clk);
    check(act, 1'b0);
    pulse(0);
    wait_for(1, 8, t);
    m_act = 1;
    check(ovl, 1'b1);
    read_cmd(8'he4, 16'hff01, 40, {8'h00, m_fw[0], m_act[0], 6'h00});
    susp <= 8'(rnd());
    repeat (3) @(posedge clk);
    check(halt, susp);
    n0 = n_fwc;
    send_cmd(8'h64, 16'h0000, 16'h0000, 0);
    repeat (20) @(posedge clk);
    check(16'(n_fwc - n0), 16'h0001);
    check(16'(last_fwc), 16'h0064);
    pulse(3);
    wait_for(2, 8, t);
    repeat (2) @(posedge clk);
    check(halt, 8'h00);
    for (int k = 1; k <= 2; k++) begin
      pulse(k);
      wait_for(1, 8, t);
      pulse(3);
      wait_for(2, 8, t);
    end
    $display("test debug mode done");
    for (int j = 0; j < 2; j++) begin
      idle <= (j == 0);
      a = 16'(rnd()) & 16'h7ffe;
      d = 16'(rnd());
      n0 = n_frz;
      send_cmd(8'hc8, a, d, 4);
      wait_for(0, 300, t);
      check(16'(r_ctl), 16'h0004);
      check(r_addr, a);
      check(r_wd, d);
      if (j == 1) check(16'(t >= 100), 16'h0001);
      if (j == 1) check(16'(n_frz > n0), 16'h0001);
      read_cmd(8'he8, a, 200, d);
    end
    idle <= 1'b1;
    $display("test memory done");
    for (int k = 0; k < 3; k++) u_host.send_bit(1'b1);
    repeat (600) @(posedge clk);
    a = 16'(rnd()) & 16'h7ffe;
    send_cmd(8'hc8, a, 16'h1234, 4);
    wait_for(0, 300, t);
    check(r_addr, a);
    $display("test timeout done");
    do_reset(1'b1);
    check({fw, act}, 16'h0003);
    read_cmd(8'he4, 16'hff01, 40, 16'h00c0);
    $display("test special reset done");
    print_verdict();
  end
endmodule : tb
